// file: src/rtc_sqw_ram_guard_power_ctl.sv
// Square wave, RAM chip-enable guard, power-on request and ID/RAM/counters
`timescale 1ns/100ps
`default_nettype none
`include "rtc_out_cfg.svh"
module rtc_sqw_ram_guard_power_ctl #(
    parameter logic [63:0] SERIAL_ID = 64'h0123_4567_89ab_cdef, // Arbitrary
    parameter logic [63:0] CUSTOM_ID = 64'hfedc_ba98_7654_3210  // Arbitrary
) (
    input  wire logic            i_core_clk,
    input  wire logic            i_reset_n,
    input  wire logic            i_power_valid,
    input  wire logic            i_aux_backup_supply,
    input  wire logic            i_supply_select,
    input  wire logic            i_main_above_5v,
    input  wire logic            i_kickstart_input_n,
    input  wire logic            i_wake_alarm,
    input  wire logic            i_osc_32k,
    input  wire logic            i_ram_select_in_n,
    input  wire logic            i_cs_n,
    input  wire logic            i_ale,
    input  wire logic            i_wr_n,
    input  wire logic            i_rd_n,
    input  wire rtc_out_pkg::byte_t i_ad,
    output var  rtc_out_pkg::byte_t o_ad,
    output logic                 o_ad_oe,
    output logic                 o_square_wave_out,
    output logic                 o_ram_select_out_n,
    output logic                 o_power_on_request_n,
    output logic                 o_mode_5v
);
    import rtc_out_pkg::*;

    state_t st;
    state_t next_st;
    logic   osc_rise;
    logic   sec_tick;
    logic   ks_fall;
    logic   wr_done;
    logic   ext_sel;
    logic   tap;
    logic   pwr_set;
    logic   pwr_clr;
    byte_t  rd_val;
    byte_t  ofs;

    always_comb begin
        osc_rise = st.osc_s2 & ~st.osc_d;
        sec_tick = osc_rise & (&st.div);
        ks_fall  = st.ks_d & ~st.ks_s2;
        wr_done  = st.wr_s2 & ~st.wr_d & ~st.cs_s2 & st.pv_s2;
        ext_sel  = st.bank & (st.addr >= `OFS_EXT_PAGE);
        ofs      = 8'h00;
        // Divider tap for the selected rate
        unique case (st.rate)
            4'h0:    tap = 1'b0;
            4'h1:    tap = st.div[6];
            4'h2:    tap = st.div[7];
            default: tap = st.div[st.rate - 4'h2];
        endcase
        // Read multiplexer
        rd_val = 8'h00;
        if (ext_sel) begin
            if (st.addr == `OFS_EXT_CTL) begin
                rd_val[`BIT_EXT_ABE]  = st.abe;
                rd_val[`BIT_EXT_FAST] = st.fast_en;
                rd_val[`BIT_EXT_WAKE] = st.wake_en;
                rd_val[`BIT_EXT_PWR]  = st.pwr_req;
            end else if (st.addr < `OFS_SERIAL + 8'h08) begin
                ofs    = st.addr - `OFS_SERIAL;
                rd_val = SERIAL_ID[ofs[2:0]*8 +: 8];
            end else if (st.addr >= `OFS_CUSTOM
                         && st.addr < `OFS_CUSTOM + 8'h08) begin
                ofs    = st.addr - `OFS_CUSTOM;
                rd_val = CUSTOM_ID[ofs[2:0]*8 +: 8];
            end else if (st.addr >= `OFS_VCC_CNT
                         && st.addr < `OFS_CYC_CNT) begin
                ofs    = st.addr - `OFS_VCC_CNT;
                rd_val = st.vcc_cnt[ofs[1:0]*8 +: 8];
            end else if (st.addr >= `OFS_CYC_CNT
                         && st.addr < `OFS_BAT_CNT) begin
                ofs    = st.addr - `OFS_CYC_CNT;
                rd_val = st.cyc_cnt[ofs[0]*8 +: 8];
            end else if (st.addr >= `OFS_BAT_CNT
                         && st.addr < `OFS_BAT_CNT + 8'h04) begin
                ofs    = st.addr - `OFS_BAT_CNT;
                rd_val = st.bat_cnt[ofs[1:0]*8 +: 8];
            end
        end else if (st.addr == `OFS_REG_A) begin
            rd_val[`BIT_A_BANK] = st.bank;
            rd_val[3:0]         = st.rate;
        end else if (st.addr == `OFS_REG_B) begin
            rd_val[`BIT_B_GATE] = st.gate;
        end else if (st.addr >= `OFS_RAM_BASE && st.addr < 8'h80) begin
            ofs    = st.addr - `OFS_RAM_BASE;
            rd_val = st.ram[ofs[6:0]];
        end
        pwr_clr = wr_done & ext_sel & (st.addr == `OFS_EXT_CTL)
                  & st.wdata[`BIT_EXT_PWR];
        pwr_set = (st.wake_en & i_wake_alarm)
                  | (ks_fall & st.abe & ~st.pv_s2);

        next_st = st;
        // Two-flop synchronisers
        next_st.pv_s1  = i_power_valid;
        next_st.pv_s2  = st.pv_s1;
        next_st.pv_d   = st.pv_s2;
        next_st.aux_s1 = i_aux_backup_supply;
        next_st.aux_s2 = st.aux_s1;
        next_st.sel_s1 = i_supply_select;
        next_st.sel_s2 = st.sel_s1;
        next_st.hi_s1  = i_main_above_5v;
        next_st.hi_s2  = st.hi_s1;
        next_st.ks_s1  = i_kickstart_input_n;
        next_st.ks_s2  = st.ks_s1;
        next_st.ks_d   = st.ks_s2;
        next_st.osc_s1 = i_osc_32k;
        next_st.osc_s2 = st.osc_s1;
        next_st.osc_d  = st.osc_s2;
        next_st.ce_s1  = i_ram_select_in_n;
        next_st.ce_s2  = st.ce_s1;
        next_st.cs_s1  = i_cs_n;
        next_st.cs_s2  = st.cs_s1;
        next_st.wr_s1  = i_wr_n;
        next_st.wr_s2  = st.wr_s1;
        next_st.wr_d   = st.wr_s2;
        next_st.rd_s1  = i_rd_n;
        next_st.rd_s2  = st.rd_s1;
        next_st.ale_s1 = i_ale;
        next_st.ale_s2 = st.ale_s1;
        next_st.ale_d  = st.ale_s2;
        next_st.ad_s1  = i_ad;
        next_st.ad_s2  = st.ad_s1;
        // Bus: address latched on falling strobe, data on write strobe
        if (st.ale_d & ~st.ale_s2 & st.pv_s2) begin
            next_st.addr = st.ad_s2;
        end
        if (~st.wr_s2) begin
            next_st.wdata = st.ad_s2;
        end
        if (wr_done) begin
            if (ext_sel) begin
                if (st.addr == `OFS_EXT_CTL) begin
                    next_st.abe     = st.wdata[`BIT_EXT_ABE];
                    next_st.fast_en = st.wdata[`BIT_EXT_FAST];
                    next_st.wake_en = st.wdata[`BIT_EXT_WAKE];
                end
            end else if (st.addr == `OFS_REG_A) begin
                next_st.bank = st.wdata[`BIT_A_BANK];
                next_st.rate = st.wdata[3:0];
            end else if (st.addr == `OFS_REG_B) begin
                next_st.gate = st.wdata[`BIT_B_GATE];
            end else if (st.addr >= `OFS_RAM_BASE && st.addr < 8'h80) begin
                next_st.ram[ofs[6:0]] = st.wdata;
            end
        end
        next_st.rdata   = rd_val;
        next_st.data_oe = ~st.rd_s2 & ~st.cs_s2 & st.pv_s2;
        // Power-on request, set wins over release
        next_st.pwr_req = (st.pwr_req & ~pwr_clr) | pwr_set;
        next_st.pwr_out_n = ~next_st.pwr_req;
        // Divider chain and counters
        if (osc_rise) begin
            next_st.div = st.div + 15'h0001;
        end
        if (sec_tick) begin
            next_st.bat_cnt = st.bat_cnt + 32'h1;
            if (st.pv_s2) begin
                next_st.vcc_cnt = st.vcc_cnt + 32'h1;
            end
        end
        if (st.pv_s2 & ~st.pv_d) begin
            next_st.cyc_cnt = st.cyc_cnt + 16'h1;
        end
        // Square wave and chip-enable share one power status
        if (st.pv_s2) begin
            next_st.sqw = st.gate & (st.fast_en ? st.osc_s2 : tap);
        end else begin
            next_st.sqw = st.fast_en & st.abe & st.aux_s2 & st.osc_s2;
        end
        next_st.ce_out_n = st.pv_s2 ? st.ce_s2 : 1'b1;
        next_st.mode_5v  = st.sel_s2 | st.hi_s2;
        if (!i_reset_n) begin
            next_st.rate     = `RST_RATE;
            next_st.bank     = 1'b0;
            next_st.gate     = 1'b0;
            next_st.abe      = 1'(`RST_EXT_CTL >> `BIT_EXT_ABE);
            next_st.fast_en  = 1'b0;
            next_st.wake_en  = 1'b0;
            next_st.pwr_req  = 1'b0;
            next_st.pwr_out_n = 1'b1;
            next_st.div      = '0;
            next_st.vcc_cnt  = 32'h0;
            next_st.bat_cnt  = 32'h0;
            next_st.cyc_cnt  = 16'h0;
            next_st.addr     = 8'h00;
            next_st.rdata    = 8'h00;
            next_st.data_oe  = 1'b0;
            next_st.sqw      = 1'b0;
            next_st.ce_out_n = 1'b1;
            next_st.mode_5v  = 1'b0;
            next_st.wr_d     = 1'b1;
            next_st.ks_d     = 1'b1;
            next_st.ale_d    = 1'b0;
            next_st.pv_d     = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        st <= next_st;
    end

    assign o_ad                 = st.rdata;
    assign o_ad_oe              = st.data_oe;
    assign o_square_wave_out    = st.sqw;
    assign o_ram_select_out_n   = st.ce_out_n;
    assign o_power_on_request_n = st.pwr_out_n;
    assign o_mode_5v            = st.mode_5v;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    ce_guard_a: assert property (st.pv_s2 |=>
        o_ram_select_out_n == $past(st.ce_s2))
        else $error("ram select not passed through");
    ce_block_a: assert property (!st.pv_s2 |=> o_ram_select_out_n)
        else $error("ram select not blocked");
    gate_off_a: assert property (st.pv_s2 && !st.gate |=>
        !o_square_wave_out) else $error("wave not gated off");
    fast_on_a: assert property (st.pv_s2 && st.gate && st.fast_en
        |=> o_square_wave_out == $past(st.osc_s2))
        else $error("fast wave wrong");
    fail_wave_a: assert property (!st.pv_s2 && !(st.abe && st.aux_s2)
        |=> !o_square_wave_out) else $error("wave runs without aux");
    tap_sel_a: assert property (st.pv_s2 && st.gate && !st.fast_en
        && st.rate == 4'h1 |=> o_square_wave_out == $past(st.div[6]))
        else $error("wrong divider tap");
    mode_sel_a: assert property (st.sel_s2 ##1 1'b1 |-> o_mode_5v)
        else $error("5V not selected");
    pwr_set_a: assert property (pwr_set |=> !o_power_on_request_n)
        else $error("power request not raised");
    pwr_rel_a: assert property (pwr_clr && !pwr_set
        |=> o_power_on_request_n) else $error("power request not released");
    wr_block_a: assert property (!st.pv_s2 |=>
        $stable(st.rate) && $stable(st.gate) && !o_ad_oe)
        else $error("write while power failed");
    cyc_cnt_a: assert property (st.pv_s2 && !st.pv_d |=>
        st.cyc_cnt == $past(st.cyc_cnt) + 16'h1)
        else $error("cycle count not advanced");

    kick_c: cover property (ks_fall && st.abe && !st.pv_s2 ##1
        !o_power_on_request_n);
    fail_c: cover property (st.pv_s2 ##1 !st.pv_s2 ##2 o_ram_select_out_n);
    fast_c: cover property (!st.pv_s2 && st.fast_en ##1 o_square_wave_out);
    read_c: cover property (o_ad_oe && st.addr == `OFS_EXT_CTL);
endmodule // rtc_sqw_ram_guard_power_ctl
`default_nettype wire

// file: src/rtc_out_cfg.svh
// Sizes, offsets, field positions and reset values of the output block
`ifndef RTC_OUT_CFG_SVH
`define RTC_OUT_CFG_SVH
`define RAM_BYTES       114
`define DIV_STAGES      15
`define OFS_REG_A       8'h0a
`define OFS_REG_B       8'h0b
`define OFS_RAM_BASE    8'h0e
`define OFS_EXT_CTL     8'h4b
`define OFS_EXT_PAGE    8'h40
`define OFS_SERIAL      8'h40
`define OFS_CUSTOM      8'h50
`define OFS_VCC_CNT     8'h58
`define OFS_CYC_CNT     8'h5c
`define OFS_BAT_CNT     8'h5e
`define BIT_A_BANK      4
`define BIT_B_GATE      3
`define BIT_EXT_ABE     7
`define BIT_EXT_FAST    6
`define BIT_EXT_WAKE    1
`define BIT_EXT_PWR     0
`define RST_RATE        4'h0
`define RST_EXT_CTL     8'h00
`endif

// file: src/rtc_out_pkg.sv
// Types of the output block: the packed state record
`include "rtc_out_cfg.svh"
package rtc_out_pkg;
    typedef logic [7:0] byte_t;
    typedef struct packed {
        logic pv_s1, pv_s2, pv_d, aux_s1, aux_s2, sel_s1, sel_s2;
        logic hi_s1, hi_s2, ks_s1, ks_s2, ks_d, osc_s1, osc_s2, osc_d;
        logic ce_s1, ce_s2, cs_s1, cs_s2, wr_s1, wr_s2, wr_d;
        logic rd_s1, rd_s2, ale_s1, ale_s2, ale_d;
        byte_t ad_s1, ad_s2, addr, wdata;
        logic [`DIV_STAGES-1:0] div;
        logic [3:0] rate;
        logic bank, gate, abe, fast_en, wake_en, pwr_req, pwr_out_n;
        logic [31:0] vcc_cnt, bat_cnt;
        logic [15:0] cyc_cnt;
        logic [`RAM_BYTES-1:0][7:0] ram;
        byte_t rdata;
        logic data_oe, sqw, ce_out_n, mode_5v;
    } state_t;
endpackage : rtc_out_pkg

// file: verification/rtc_host_model.sv
// Host bus master model for the multiplexed register bus
`timescale 1ns/100ps
`default_nettype none
module rtc_host_model (
    input  wire logic               i_core_clk,
    input  wire logic               i_ad_oe,
    input  wire rtc_out_pkg::byte_t i_ad,
    output logic                    o_cs_n = 1'b1,
    output logic                    o_ale  = 1'b0,
    output logic                    o_wr_n = 1'b1,
    output logic                    o_rd_n = 1'b1,
    output rtc_out_pkg::byte_t      o_ad   = 8'h5a
);
    import rtc_out_pkg::*;
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    // Address pulse, each level held three cycles
    task automatic latch(input byte_t a);
        o_ale = 1'b1;
        o_ad = a;
        wait_n(3);
        o_ale = 1'b0;
        wait_n(3);
    endtask
    task automatic wr(input byte_t a, input byte_t d);
        latch(a);
        o_cs_n = 1'b0;
        o_wr_n = 1'b0;
        o_ad = d;
        wait_n(4);
        o_wr_n = 1'b1;
        wait_n(3);
        o_cs_n = 1'b1;
        o_ad = ~d;
        wait_n(3);
    endtask
    // Strobes held until output enable is seen, bounded
    task automatic rd(input byte_t a, output byte_t d, output logic ok);
        latch(a);
        o_ad = ~a;
        o_cs_n = 1'b0;
        o_rd_n = 1'b0;
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(negedge i_core_clk);
            ok = (i_ad_oe === 1'b1);
        end
        d = i_ad;
        o_rd_n = 1'b1;
        o_cs_n = 1'b1;
        wait_n(4);
    endtask
endmodule // rtc_host_model
`default_nettype wire

// file: verification/rtc_sqw_ram_guard_power_ctl_bench.sv
// Self-checking bench of the square wave, RAM guard and power control block
`timescale 1ns/100ps
`default_nettype none
`include "rtc_out_cfg.svh"
module rtc_sqw_ram_guard_power_ctl_bench;
    import rtc_out_pkg::*;
    localparam logic [63:0] SER = 64'h1122_3344_5566_7788; // Arbitrary
    localparam logic [63:0] CUS = 64'h99aa_bbcc_ddee_f001; // Arbitrary
    logic  clk = 0, rst_n = 0, pv = 1, aux = 0, sel = 0, hi = 0;
    logic  ks_n = 1, wake = 0, osc = 0, cein_n = 1, ok;
    logic  cs_n, ale, wr_n, rd_n, ad_oe, sqw, ceo_n, pwr_n, m5;
    byte_t ad_h, ad_d, rdv, a, d;
    int    n_mismatch = 0, checks = 0, oc = 0, t;
    rtc_sqw_ram_guard_power_ctl #(.SERIAL_ID(SER), .CUSTOM_ID(CUS)) u_dut (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_power_valid(pv),
        .i_aux_backup_supply(aux), .i_supply_select(sel),
        .i_main_above_5v(hi), .i_kickstart_input_n(ks_n),
        .i_wake_alarm(wake), .i_osc_32k(osc), .i_ram_select_in_n(cein_n),
        .i_cs_n(cs_n), .i_ale(ale), .i_wr_n(wr_n), .i_rd_n(rd_n),
        .i_ad(ad_h), .o_ad(ad_d), .o_ad_oe(ad_oe),
        .o_square_wave_out(sqw), .o_ram_select_out_n(ceo_n),
        .o_power_on_request_n(pwr_n), .o_mode_5v(m5));
    rtc_host_model h (.i_core_clk(clk), .i_ad_oe(ad_oe), .i_ad(ad_d),
        .o_cs_n(cs_n), .o_ale(ale), .o_wr_n(wr_n), .o_rd_n(rd_n),
        .o_ad(ad_h));
    initial forever #50 clk = ~clk;
    // 32.768 kHz oscillator, half period 153 cycles
    always @(negedge clk) begin
        oc <= (oc == 152) ? 0 : oc + 1;
        if (oc == 152) osc <= ~osc;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    function automatic logic exp_ram_sel(input logic valid, input logic ce_n);
        return valid ? ce_n : 1'b1;
    endfunction
    task automatic print_verdict;
        if (n_mismatch == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic toggles(input int n, output int c);
        logic last;
        c = 0;
        last = sqw;
        repeat (n) begin
            @(negedge clk);
            if (sqw !== last) c++;
            last = sqw;
        end
    endtask
    initial begin
        #5_000_000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        t = $urandom(32'ha62d);
        repeat (10) @(negedge clk);
        check(ceo_n, 1'b1);
        check(pwr_n, 1'b1);
        rst_n = 1'b1;
        h.wait_n(3);
        for (int i = 0; i < 5; i++) begin
            a = (i == 0) ? 8'h0e : (i == 1) ? 8'h7f : 8'h0e + 8'($urandom % 114);
            d = 8'($urandom);
            h.wr(a, d);
            h.rd(a, rdv, ok);
            check(rdv, d);
        end
        h.wr(`OFS_REG_A, 8'h13);
        for (int i = 0; i < 8; i++) begin
            h.rd(`OFS_SERIAL + 8'(i), rdv, ok);
            check(rdv, SER[8*i +: 8]);
            h.rd(`OFS_CUSTOM + 8'(i), rdv, ok);
            check(rdv, CUS[8*i +: 8]);
        end
        h.wr(`OFS_SERIAL, ~SER[7:0]);
        h.rd(`OFS_SERIAL, rdv, ok);
        check(rdv, SER[7:0]);
        h.wr(`OFS_REG_B, 8'h08);
        toggles(1500, t);
        check(t > 1 && t < 4, 1'b1);
        h.wr(`OFS_REG_B, 8'h00);
        toggles(1500, t);
        check(t, 0);
        h.wr(`OFS_REG_B, 8'h08);
        h.wr(`OFS_EXT_CTL, 8'h42);
        toggles(400, t);
        check(t > 1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            cein_n = (i == 0) ? 1'b0 : 1'($urandom);
            {sel, hi} = 2'(i);
            aux = 1'($urandom);
            ks_n = (i == 7) ? 1'b1 : 1'($urandom);
            h.wait_n(4);
            check(ceo_n, exp_ram_sel(pv, cein_n));
            check(pwr_n, 1'b1);
            check(m5, sel | hi);
        end
        ks_n = 1'b0;
        h.wait_n(6);
        check(pwr_n, 1'b1);
        ks_n = 1'b1;
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        check(pwr_n, 1'b0);
        h.wr(`OFS_EXT_CTL, 8'hc3);
        check(pwr_n, 1'b1);
        h.rd(`OFS_CYC_CNT, d, ok);
        cein_n = 1'b0;
        aux = 1'b1;
        pv = 1'b0;
        h.wait_n(5);
        check(ceo_n, exp_ram_sel(pv, cein_n));
        toggles(400, t);
        check(t > 1, 1'b1);
        h.rd(8'h0e, rdv, ok);
        check(ok, 1'b0);
        ks_n = 1'b0;
        h.wait_n(6);
        check(pwr_n, 1'b0);
        ks_n = 1'b1;
        aux = 1'b0;
        h.wait_n(4);
        toggles(400, t);
        check(t, 0);
        pv = 1'b1;
        h.wait_n(5);
        check(ceo_n, 1'b0);
        h.rd(`OFS_CYC_CNT, rdv, ok);
        check(rdv, d + 8'h01);
        h.wr(`OFS_EXT_CTL, 8'hc3);
        check(pwr_n, 1'b1);
        print_verdict();
    end
endmodule // rtc_sqw_ram_guard_power_ctl_bench
`default_nettype wire
